/* File: verilog/background_debug_control.sv */
// Purpose: Single-wire debug unit with register overlay and mode control.
// Assumes: Pins are synchronous to clk; host keeps the bit protocol.
// Notes:   CPU registers are modelled as ports of the core interface.
//
// Contract
// - Host falling edge; sample at nine; sixteen/bit
// - Firmware commands only when permitted and active
// - Codes 63-67 read_program_counter_cmd D X Y SP
// - Codes 43-47 write_program_counter_cmd D X Y SP
// - Code 62: X plus two, read word
// - Code 42: X plus two, write word
// - Code 10: one instruction, set step bit
// - Code 18: set tagging, resume; clears on entry
// - No serial commands while tagging is on
// - Code 08: restore registers, write status, resume
// - Seven debug register bytes in overlay
// - Overlay hides normal memory at those addresses
// - Status bit 7 permits debug activation
// - Status bit 6 reads active and waiting
// - Status bit 4 marks valid shifter data
// - Entry saves return address, selects debug ROM
// - Entry saves D, copies flags to holding
// - Permit tested; loop leaves PC SP X Y
// - Low debug pin selects special modes
// - High debug pin selects normal modes
// - Normal mode changes once, normal only
// - Special mode bits rewrite freely
// - Leaving special needs two writes
`timescale 1ns/1ps
`include "debug_ctrl_defs.svh"
module background_debug_control
  import debug_ctrl_pkg::*;
(
  input  wire logic        clk,                 // Bus clock.
  input  wire logic        resetn,              // Synchronous reset, low.
  input  wire logic        debug_pin_in,        // Level on the debug pin.
  output logic             debug_pin_out,       // Value driven on the pin.
  output logic             debug_pin_oe,        // High while driving.
  input  wire logic        mode_select_low_pin, // Mode pin, low bit.
  input  wire logic        mode_select_high_pin,// Mode pin, high bit.
  input  wire logic        debug_request,       // Enter-debug request.
  input  wire logic        step_done,           // User instruction retired.
  input  wire logic [15:0] cpu_pc,              // Live user PC.
  input  wire logic [15:0] cpu_d,               // Live user D.
  input  wire logic [15:0] cpu_x,               // Live user X.
  input  wire logic [15:0] cpu_y,               // Live user Y.
  input  wire logic [15:0] cpu_sp,              // Live user SP.
  input  wire logic [7:0]  condition_flags,     // Live user flags.
  output logic             reg_load,            // Pulse: load cpu register.
  output logic [2:0]       reg_sel,             // 0 PC 1 D 2 X 3 Y 4 SP.
  output logic [15:0]      reg_value,           // Value to load.
  output logic             cpu_resume,          // Pulse: run user code.
  output logic [15:0]      resume_pc,           // Where to resume.
  output logic             cpu_halted,          // CPU runs debug ROM.
  output logic             debug_rom_sel,       // Overlay in the map.
  input  wire logic [15:0] bus_addr,            // CPU bus address.
  input  wire logic        bus_wr,              // CPU bus write strobe.
  input  wire logic        bus_rd,              // CPU bus read strobe.
  input  wire logic [7:0]  bus_wdata,           // CPU write data.
  output logic [7:0]       bus_rdata,           // Overlay read data.
  output logic             bus_hit,             // Overlay claims access.
  output logic             mem_req,             // Pulse: word memory access.
  output logic             mem_we,              // Memory write.
  output logic [15:0]      mem_addr,            // Memory word address.
  output logic [15:0]      mem_wdata,           // Memory write word.
  input  wire logic [15:0] mem_rdata,           // Memory read word.
  input  wire logic        mem_ack,             // Memory done.
  input  wire logic        mode_wr,             // Mode register write.
  input  wire logic [2:0]  mode_wdata,          // Normal flag and pins.
  output logic [2:0]       op_mode              // Current operating mode.
);

  // ***
  // Storage.
  // ***
  logic [7:0]  debug_instruction;    // Last command byte.
  logic [7:0]  debug_status;         // Permit/active/tag/valid/step.
  logic [15:0] debug_serial_shift;   // Serial shift register.
  logic [15:0] debug_address;        // Address register.
  logic [7:0]  saved_flags_holding;  // Saved user flags.
  logic [15:0] saved_d;              // User D on entry.
  logic [15:0] saved_ret;            // Return address on entry.
  logic [15:0] x_work;               // Working X for next commands.
  ser_state_e  state;                // Serial engine state.
  logic [4:0]  bit_cnt;              // Cycles within a bit.
  logic [4:0]  bits_left;            // Bits left in a field.
  logic        pin_q;                // Previous pin level.
  logic        in_bit;               // Bit window open.
  logic        mode_changed;         // Normal mode change used.
  logic        special_arm;          // First leave-special write seen.
  logic        strap_done;           // Mode pins caught after reset.
  logic        stepping;             // Waiting for step completion.

  // True when the code is one of the sixteen-bit read commands.
  function automatic logic is_read(input logic [7:0] c);
    is_read = (c >= `CMD_READ_NEXT) && (c <= `CMD_READ_STACK_POINTER_CMD);
  endfunction : is_read

  // True when the code carries sixteen bits from the host.
  function automatic logic is_write(input logic [7:0] c);
    is_write = (c >= `CMD_WRITE_NEXT) && (c <= `CMD_WRITE_STACK_POINTER_CMD);
  endfunction : is_write

  // Register selector for codes ending in 3..7.
  function automatic logic [2:0] sel_of(input logic [7:0] c);
    sel_of = 3'(c[2:0] - 3'h3);
  endfunction : sel_of

  logic active;       // Active and waiting for commands.
  logic falling;      // Host started a bit.
  logic sample_now;   // Sampling instant of the bit.
  logic bit_end;      // Last cycle of the bit.
  assign active     = debug_status[`ST_ACTIVE];
  assign falling    = pin_q & ~debug_pin_in;
  assign sample_now = in_bit && (bit_cnt == `BIT_SAMPLE);
  assign bit_end    = in_bit && (bit_cnt == `BIT_CYCLES - 5'd1);

  // ***
  // Bit timing.
  // ***
  // Each bit is resynchronised on the host's falling edge, so clock
  // drift between pod and chip only matters within one bit.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_q   <= 1'b1;
      in_bit  <= 1'b0;
      bit_cnt <= 5'd0;
    end else begin
      pin_q <= debug_pin_in;
      if (!in_bit && falling) begin
        in_bit  <= 1'b1;
        bit_cnt <= 5'd1;
      end else if (bit_end) begin
        in_bit  <= 1'b0;
        bit_cnt <= 5'd0;
      end else if (in_bit) begin
        bit_cnt <= bit_cnt + 5'd1;
      end
    end
  end

  // ***
  // Serial command engine.
  // ***
  // Commands are taken only while permitted, active and not tagging.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state              <= S_IDLE;
      bits_left          <= 5'd0;
      debug_instruction  <= 8'h00;
      debug_serial_shift <= 16'h0000;
      x_work             <= 16'h0000;
      mem_req            <= 1'b0;
      mem_we             <= 1'b0;
      mem_addr           <= 16'h0000;
      mem_wdata          <= 16'h0000;
      reg_load           <= 1'b0;
      reg_sel            <= 3'd0;
      reg_value          <= 16'h0000;
      debug_pin_out      <= 1'b1;
      debug_pin_oe       <= 1'b0;
    end else begin
      mem_req  <= 1'b0;
      reg_load <= 1'b0;
      case (state)
        S_IDLE: begin
          debug_pin_oe <= 1'b0;
          // Tagging blocks serial commands entirely.
          if (active && debug_status[`ST_PERMIT]
              && !debug_status[`ST_TAG]) begin
            state     <= S_CMD;
            bits_left <= 5'd8;
            x_work    <= cpu_x;
          end
        end
        S_CMD: begin
          if (!active) begin
            state <= S_IDLE;
          end else if (sample_now) begin
            debug_instruction <= {debug_instruction[6:0], debug_pin_in};
            bits_left <= bits_left - 5'd1;
            if (bits_left == 5'd1) begin
              state <= is_write({debug_instruction[6:0], debug_pin_in})
                       ? S_DATA : S_EXEC;
              bits_left <= 5'd16;
            end
          end
        end
        S_DATA: begin
          if (sample_now) begin
            debug_serial_shift <= {debug_serial_shift[14:0], debug_pin_in};
            bits_left <= bits_left - 5'd1;
            if (bits_left == 5'd1) begin
              state <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          if (debug_instruction == `CMD_READ_NEXT
              || debug_instruction == `CMD_WRITE_NEXT) begin
            // X moves first, then the word at the new X is used.
            if (!mem_req && !mem_ack && mem_addr != x_work + 16'h0002)
            begin
              mem_req   <= 1'b1;
              mem_we    <= (debug_instruction == `CMD_WRITE_NEXT);
              mem_addr  <= x_work + 16'h0002;
              mem_wdata <= debug_serial_shift;
            end else if (mem_ack) begin
              x_work    <= x_work + 16'h0002;
              reg_load  <= 1'b1;
              reg_sel   <= 3'd2;
              reg_value <= x_work + 16'h0002;
              if (!mem_we) begin
                debug_serial_shift <= mem_rdata;
              end
              mem_addr  <= 16'h0000;
              state     <= mem_we ? S_IDLE : S_SEND;
              bits_left <= 5'd16;
            end
          end else if (is_read(debug_instruction)) begin
            case (sel_of(debug_instruction))
              3'd0: debug_serial_shift <= saved_ret;
              3'd1: debug_serial_shift <= saved_d;
              3'd2: debug_serial_shift <= x_work;
              3'd3: debug_serial_shift <= cpu_y;
              default: debug_serial_shift <= cpu_sp;
            endcase
            state     <= S_SEND;
            bits_left <= 5'd16;
          end else if (is_write(debug_instruction)) begin
            reg_load  <= 1'b1;
            reg_sel   <= sel_of(debug_instruction);
            reg_value <= debug_serial_shift;
            state     <= S_IDLE;
          end else begin
            // Go, step and tag commands are handled by the entry logic.
            state <= S_RUN;
          end
        end
        S_SEND: begin
          // Device drives the bit value after the host's edge, MSB first.
          if (in_bit && bit_cnt == 5'd2) begin
            debug_pin_oe  <= 1'b1;
            debug_pin_out <= debug_serial_shift[15];
          end else if (bit_end && debug_pin_oe) begin // Not the cmd tail.
            debug_pin_oe       <= 1'b0;
            debug_pin_out      <= 1'b1;
            debug_serial_shift <= {debug_serial_shift[14:0], 1'b0};
            bits_left          <= bits_left - 5'd1;
            if (bits_left == 5'd1) begin
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ***
  // Entry, exit and status.
  // ***
  // Entry captures the user context; exit restores it and resumes.
  logic go_cmd; // Run-class command ready to execute.
  assign go_cmd = (state == S_RUN);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      debug_status        <= `STATUS_RESET;
      saved_flags_holding <= `FLAGS_RESET;
      saved_d             <= 16'h0000;
      saved_ret           <= 16'h0000;
      cpu_resume          <= 1'b0;
      resume_pc           <= 16'h0000;
      cpu_halted          <= 1'b0;
      debug_rom_sel       <= 1'b0;
      stepping            <= 1'b0;
    end else begin
      cpu_resume <= 1'b0;
      if (!strap_done && !mode_select_low_pin && !mode_select_high_pin
          && !debug_pin_in) begin
        // Special single chip comes up permitted and active.
        debug_status[`ST_PERMIT] <= 1'b1;
        debug_status[`ST_ACTIVE] <= 1'b1;
        saved_ret     <= cpu_pc;
        saved_d       <= cpu_d;
        cpu_halted    <= 1'b1;
        debug_rom_sel <= 1'b1;
      end else if ((debug_request || (stepping && step_done))
                   && !cpu_halted) begin
        saved_ret     <= cpu_pc;
        debug_rom_sel <= 1'b1;
        saved_d       <= cpu_d;
        saved_flags_holding <= condition_flags;
        cpu_halted    <= 1'b1;
        stepping      <= 1'b0;
        debug_status[`ST_TAG] <= 1'b0;
        // Without permit the firmware returns at once to user code.
        debug_status[`ST_ACTIVE] <= debug_status[`ST_PERMIT];
        if (!debug_status[`ST_PERMIT]) begin
          cpu_resume    <= 1'b1;
          resume_pc     <= cpu_pc;
          cpu_halted    <= 1'b0;
          debug_rom_sel <= 1'b0;
        end
      end else if (go_cmd) begin
        // Restore user state and write status before the jump.
        debug_status[`ST_ACTIVE] <= 1'b0;
        debug_status[`ST_STEP]   <= (debug_instruction == `CMD_STEP);
        debug_status[`ST_TAG]    <= (debug_instruction == `CMD_TAG_GO);
        stepping      <= (debug_instruction == `CMD_STEP);
        cpu_resume    <= 1'b1;
        resume_pc     <= saved_ret;
        cpu_halted    <= 1'b0;
        debug_rom_sel <= 1'b0;
      end else if (reg_load && reg_sel == 3'd0) begin
        saved_ret <= reg_value;
      end else if (reg_load && reg_sel == 3'd1) begin
        saved_d <= reg_value;
      end else if (bus_wr && bus_addr == `OFS_STATUS && !active) begin
        // Only permit is writable; the other bits are hardware owned.
        debug_status[`ST_PERMIT] <= bus_wdata[`ST_PERMIT];
      end else if (bus_wr && bus_addr == `OFS_FLAGS) begin
        saved_flags_holding <= bus_wdata;
      end
      // Shifter holds valid data between a completed field and its use.
      debug_status[`ST_VALID] <= (state == S_EXEC) || (state == S_SEND);
      debug_status[2:0] <= 3'b000;
    end
  end

  // ***
  // Overlay register access.
  // ***
  // Overlay decode; the address register is written only by the CPU.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata     <= 8'h00;
      bus_hit       <= 1'b0;
      debug_address <= 16'h0000;
    end else begin
      bus_hit   <= debug_rom_sel && bus_rd
                   && (bus_addr[15:8] == `OVERLAY_BASE);
      if (bus_addr == `OFS_INSTR) begin
        bus_rdata <= debug_instruction;
      end else if (bus_addr == `OFS_STATUS) begin
        bus_rdata <= {debug_status[7:3], 3'b000};
      end else if (bus_addr == `OFS_SHIFT_HI) begin
        bus_rdata <= debug_serial_shift[15:8];
      end else if (bus_addr == `OFS_SHIFT_LO) begin
        bus_rdata <= debug_serial_shift[7:0];
      end else if (bus_addr == `OFS_ADDR_HI) begin
        bus_rdata <= debug_address[15:8];
      end else if (bus_addr == `OFS_ADDR_LO) begin
        bus_rdata <= debug_address[7:0];
      end else if (bus_addr == `OFS_FLAGS) begin
        bus_rdata <= saved_flags_holding;
      end else begin
        bus_rdata <= 8'h00;
      end
      if (bus_wr && bus_addr == `OFS_ADDR_HI) begin
        debug_address[15:8] <= bus_wdata;
      end else if (bus_wr && bus_addr == `OFS_ADDR_LO) begin
        debug_address[7:0] <= bus_wdata;
      end
    end
  end

  // ***
  // Operating mode.
  // ***
  // Pins are caught in the first clock after reset release.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_mode      <= 3'b000;
      strap_done   <= 1'b0;
      mode_changed <= 1'b0;
      special_arm  <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      op_mode    <= {debug_pin_in, mode_select_high_pin,
                     mode_select_low_pin};
    end else if (mode_wr) begin
      if (op_mode[2]) begin
        // Normal: one change, to a normal mode only; 10 is reserved.
        if (!mode_changed && mode_wdata[2]) begin
          op_mode      <= mode_wdata;
          mode_changed <= 1'b1;
        end
      end else if (mode_wdata[2]) begin
        // The first write that sets the normal flag is ignored.
        special_arm <= 1'b1;
        if (special_arm) begin
          op_mode <= mode_wdata;
        end
      end else begin
        op_mode <= mode_wdata;
      end
    end
  end

endmodule : background_debug_control

/* File: inc/debug_ctrl_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Bus clock of 50 MHz.
// Notes:   Definitions only.
`ifndef DEBUG_CTRL_DEFS_SVH
`define DEBUG_CTRL_DEFS_SVH
// ***
// Register overlay offsets.
// ***
`define OFS_INSTR      16'hFF00
`define OFS_STATUS     16'hFF01
`define OFS_SHIFT_HI   16'hFF02
`define OFS_SHIFT_LO   16'hFF03
`define OFS_ADDR_HI    16'hFF04
`define OFS_ADDR_LO    16'hFF05
`define OFS_FLAGS      16'hFF06
`define OVERLAY_BASE   8'hFF
// ***
// Status field positions and reset values.
// ***
`define ST_PERMIT      7
`define ST_ACTIVE      6
`define ST_TAG         5
`define ST_VALID       4
`define ST_STEP        3
`define STATUS_RESET   8'h00
`define FLAGS_RESET    8'h00
// ***
// Firmware command codes.
// ***
`define CMD_READ_NEXT  8'h62
`define CMD_READ_PROGRAM_COUNTER_CMD    8'h63
`define CMD_READ_D     8'h64
`define CMD_READ_X     8'h65
`define CMD_READ_Y     8'h66
`define CMD_READ_STACK_POINTER_CMD    8'h67
`define CMD_WRITE_NEXT 8'h42
`define CMD_WRITE_PROGRAM_COUNTER_CMD   8'h43
`define CMD_WRITE_D    8'h44
`define CMD_WRITE_X    8'h45
`define CMD_WRITE_Y    8'h46
`define CMD_WRITE_STACK_POINTER_CMD   8'h47
`define CMD_GO         8'h08
`define CMD_STEP       8'h10
`define CMD_TAG_GO     8'h18
// ***
// Serial timing, in bus-clock cycles.
// ***
`define BIT_SAMPLE     5'd9
`define BIT_CYCLES     5'd16
`endif

/* File: inc/debug_ctrl_pkg.sv */
// Purpose: Types shared by the debug control block.
// Assumes: Used with debug_ctrl_defs.svh.
// Notes:   Types only.
package debug_ctrl_pkg;
  // Serial engine states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CMD   = 3'b001,
    S_DATA  = 3'b011,
    S_EXEC  = 3'b010,
    S_SEND  = 3'b110,
    S_RUN   = 3'b111
  } ser_state_e;
  // Operating modes: bit 2 is the normal flag, low two bits the mode pins.
  typedef logic [2:0] op_mode_t;
endpackage : debug_ctrl_pkg

/* File: testbench/debug_host_pod.sv */
// Purpose: Host pod model that works the single debug wire.
// Assumes: The wire has a pull-up; the host only ever pulls it low.
// Notes:   The bench calls the tasks; the host starts every bit.
`timescale 1ns/1ps
module debug_host_pod (
  input  wire logic clk,           // Bus clock.
  input  wire logic strap_low,     // Holds the wire low as a reset strap.
  input  wire logic debug_pin_oe,  // Device drives the wire.
  input  wire logic debug_pin_out, // Device drive value.
  output logic      debug_pin      // Resolved wire level.
);
  // ***
  // Wire and bit timing.
  // ***
  logic host_low = 1'b0; // Host pulls the wire low.
  // Pull-up: an undriven wire reads 1.
  assign debug_pin = (host_low | strap_low) ? 1'b0 :
                     (debug_pin_oe ? debug_pin_out : 1'b1);
  // A one is a short low pulse; a zero stays low past the sample point.
  task automatic send_bit(input logic b);
    @(posedge clk) host_low <= 1'b1;
    repeat (b ? 4 : 13) @(posedge clk);
    host_low <= 1'b0;
    repeat (b ? 13 : 4) @(posedge clk);
  endtask : send_bit
  task automatic send_cmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) send_bit(c[i]);
  endtask : send_cmd
  task automatic send_word(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) send_bit(v[i]);
  endtask : send_word
  // The host opens each bit with one low cycle, then lets the device drive.
  task automatic recv_word(output logic [15:0] v);
    repeat (16) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) host_low <= 1'b1;
      @(posedge clk) host_low <= 1'b0;
      repeat (8) @(posedge clk);
      v[i] = debug_pin;
      repeat (7) @(posedge clk);
    end
  endtask : recv_word
endmodule : debug_host_pod

/* File: testbench/background_debug_control_checker.sv */
// Purpose: Port checks for the debug control block.
// Assumes: One clock and a synchronous low reset.
// Notes:   Bound into every instance of the block.
`timescale 1ns/1ps
`include "debug_ctrl_defs.svh"
module background_debug_control_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        debug_pin_in,
  input wire logic        debug_pin_oe,
  input wire logic        mode_select_low_pin,
  input wire logic        mode_select_high_pin,
  input wire logic [15:0] cpu_x,
  input wire logic        cpu_halted,
  input wire logic        debug_rom_sel,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_hit,
  input wire logic        mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [2:0]  op_mode
);
  // ***
  // Assertions.
  // ***
  wire logic [2:0] straps = {debug_pin_in, mode_select_high_pin,
                             mode_select_low_pin}; // Reset-time pins.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_status_low_zero: assert property (
    bus_rd && bus_addr == `OFS_STATUS |=> bus_rdata[2:0] == 3'h0)
    else $error("Status low bits set.");
  a_overlay_hit: assert property (
    bus_rd && debug_rom_sel && bus_addr[15:8] == `OVERLAY_BASE |=> bus_hit)
    else $error("Overlay read not claimed.");
  a_no_hit_off: assert property (
    !debug_rom_sel |=> !bus_hit) else $error("Claim without overlay.");
  a_next_addr: assert property (
    mem_req |-> mem_addr == cpu_x + 16'h0002)
    else $error("Word access not at X plus two.");
  a_oe_halted: assert property (
    debug_pin_oe |-> cpu_halted) else $error("Wire driven while running.");
  a_oe_stands: assert property (
    $rose(debug_pin_oe) |-> debug_pin_oe [*8])
    else $error("Wire drive cut short.");
  a_strap_mode: assert property (
    $rose(resetn) && straps != 3'h6 |=> op_mode == $past(straps))
    else $error("Mode not taken from pins.");
  a_normal_stays: assert property (
    op_mode[2] |=> op_mode[2]) else $error("Left normal mode.");
endmodule : background_debug_control_checker
bind background_debug_control background_debug_control_checker i_checker (.*);

/* File: testbench/background_debug_control_bench.sv */
// Purpose: Self-checking bench for the debug control block.
// Assumes: Host pod on the wire; CPU registers and memory modelled here.
// Notes:   Tests run in order from a special-mode reset; t_modes resets again into normal mode.
`timescale 1ns/1ps
`include "debug_ctrl_defs.svh"
module background_debug_control_bench;
  // ***
  // Stimulus, models and tests.
  // ***
  logic clk = 1'b0, resetn = 1'b0, strap_low = 1'b1, debug_request = 1'b0;
  logic mode_select_low_pin = 1'b0, mode_select_high_pin = 1'b0;
  logic step_done = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, mem_ack = 1'b0;
  logic mode_wr = 1'b0, debug_pin_in, debug_pin_out, debug_pin_oe, mem_we;
  logic reg_load, cpu_resume, cpu_halted, debug_rom_sel, bus_hit, mem_req;
  logic [2:0]  mode_wdata = 3'h0, reg_sel, op_mode;
  logic [7:0]  condition_flags = 8'h3C, bus_wdata = 8'h00, bus_rdata;
  logic [15:0] bus_addr = 16'h0000, mem_rdata = 16'hBEEF, w, x0, m_addr, m_wd;
  logic [15:0] reg_value, resume_pc, mem_addr, mem_wdata;
  logic [15:0] cpu_r [5] = '{16'h1111, 16'h2222, 16'h3330, 16'h4444, 16'h5550};
  int err_total = 0, samples_checked = 0, n_load = 0, n_res = 0, n_oe = 0, n0;
  always #10 clk = ~clk;
  debug_host_pod i_debug_host_pod (.clk(clk), .strap_low(strap_low),
    .debug_pin_oe(debug_pin_oe), .debug_pin_out(debug_pin_out),
    .debug_pin(debug_pin_in));
  background_debug_control i_background_debug_control (.*,
    .cpu_pc(cpu_r[0]), .cpu_d(cpu_r[1]), .cpu_x(cpu_r[2]),
    .cpu_y(cpu_r[3]), .cpu_sp(cpu_r[4]));
  // CPU and memory side: acks requests, applies register loads, counts load and resume pulses and drive cycles.
  always @(posedge clk) begin
    mem_ack <= (mem_req === 1'b1);
    if (reg_load === 1'b1) cpu_r[reg_sel] <= reg_value;
    if (reg_load === 1'b1) n_load++;
    if (mem_req === 1'b1) {m_addr, m_wd} <= {mem_addr, mem_wdata};
    if (cpu_resume === 1'b1) n_res++;
    if (debug_pin_oe === 1'b1) n_oe++;
  end
  task automatic check(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // The host never writes status while debug runs.
  task automatic rd_reg(input logic [15:0] a);
    @(posedge clk) bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk) bus_rd <= 1'b0;
    #1;
  endtask : rd_reg
  task automatic wait_chg(ref int c, input int c0);
    for (int k = 0; k < 400 && c == c0; k++) @(posedge clk);
    @(posedge clk);
  endtask : wait_chg
  task automatic wait_halt();
    for (int k = 0; k < 400 && cpu_halted !== 1'b1; k++) @(posedge clk);
  endtask : wait_halt
  task automatic set_mode(input logic [2:0] v, exp);
    @(posedge clk) mode_wr <= 1'b1;
    mode_wdata <= v;
    @(posedge clk) mode_wr <= 1'b0;
    repeat (2) @(posedge clk);
    check("op_mode", {13'h0, exp}, {13'h0, op_mode});
  endtask : set_mode
  task automatic do_reset(input logic s, hi, lo);
    @(posedge clk) resetn <= 1'b0;
    {strap_low, mode_select_high_pin, mode_select_low_pin} <= {s, hi, lo};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    strap_low <= 1'b0;
  endtask : do_reset
  task automatic t_entry();
    check("op_mode", 16'h0, {13'h0, op_mode});
    rd_reg(`OFS_STATUS);
    check("status", 16'hC0, {8'h0, bus_rdata});
    check("hit", 16'h1, {15'h0, bus_hit});
    check("rom_sel", 16'h1, {15'h0, debug_rom_sel});
    $display("END entry");
  endtask : t_entry
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      i_debug_host_pod.send_cmd(8'(`CMD_READ_PROGRAM_COUNTER_CMD + i));
      i_debug_host_pod.recv_word(w);
      check("read", cpu_r[i], w);
    end
    x0 = cpu_r[2];
    n0 = n_load;
    i_debug_host_pod.send_cmd(`CMD_READ_NEXT);
    i_debug_host_pod.recv_word(w);
    wait_chg(n_load, n0);
    check("next data", 16'hBEEF, w);
    check("new X", x0 + 16'h2, cpu_r[2]);
    n0 = n_load;
    i_debug_host_pod.send_cmd(`CMD_WRITE_NEXT);
    i_debug_host_pod.send_word(16'h0C35);
    wait_chg(n_load, n0);
    check("store addr", x0 + 16'h4, m_addr);
    check("store data", 16'h0C35, m_wd);
    for (int i = 0; i < 5; i++) begin
      n0 = n_load;
      i_debug_host_pod.send_cmd(8'(`CMD_WRITE_PROGRAM_COUNTER_CMD + i));
      i_debug_host_pod.send_word(16'hA0A0 + 16'(i));
      wait_chg(n_load, n0);
      check("write", 16'hA0A0 + 16'(i), cpu_r[i]);
    end
    $display("END registers");
  endtask : t_regs
  task automatic t_run(input logic [7:0] cmd, mask, exp);
    n0 = n_res;
    i_debug_host_pod.send_cmd(cmd);
    wait_chg(n_res, n0);
    check("resume", 16'(n0 + 1), 16'(n_res));
    if (cmd == `CMD_STEP) begin
      @(posedge clk) step_done <= 1'b1;
      @(posedge clk) step_done <= 1'b0;
      wait_halt();
    end
    rd_reg(`OFS_STATUS);
    check("status", {8'h0, exp}, {8'h0, bus_rdata & mask});
    n0 = n_oe;
    i_debug_host_pod.send_cmd(`CMD_READ_PROGRAM_COUNTER_CMD);
    i_debug_host_pod.recv_word(w);
    if (cmd != `CMD_STEP) check("drive", 16'(n0), 16'(n_oe));
    $display("END run %h", cmd);
  endtask : t_run
  task automatic t_reentry();
    @(posedge clk) condition_flags <= 8'h96;
    debug_request <= 1'b1;
    @(posedge clk) debug_request <= 1'b0;
    wait_halt();
    rd_reg(`OFS_STATUS);
    check("status", 16'hC0, {8'h0, bus_rdata & 8'hE0});
    rd_reg(`OFS_FLAGS);
    check("flags", 16'h96, {8'h0, bus_rdata});
    check("rom_sel", 16'h1, {15'h0, debug_rom_sel});
    $display("END reentry");
  endtask : t_reentry
  task automatic t_modes();
    set_mode(3'h3, 3'h3);
    set_mode(3'h1, 3'h1);
    set_mode(3'h5, 3'h1);
    set_mode(3'h5, 3'h5);
    set_mode(3'h7, 3'h7);
    set_mode(3'h4, 3'h7);
    do_reset(1'b0, 1'b1, 1'b1);
    check("op_mode", 16'h7, {13'h0, op_mode});
    rd_reg(`OFS_STATUS);
    check("status", 16'h00, {8'h0, bus_rdata});
    $display("END modes");
  endtask : t_modes
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    do_reset(1'b1, 1'b0, 1'b0);
    t_entry();
    t_regs();
    t_run(`CMD_STEP, 8'hE8, 8'hC8);
    t_run(`CMD_TAG_GO, 8'hE0, 8'hA0);
    t_reentry();
    t_run(`CMD_GO, 8'hE8, 8'h80);
    t_modes();
    final_report();
  end
  initial begin
    #1_000_000;
    err_total++;
    final_report();
  end
endmodule : background_debug_control_bench
